// ==== src/dsm_pkg.sv ====
// dsm_pkg: constants shared by the deserializer output-state and mode block.
// assumes a 10 MHz system clock and a recovered link clock of its own.
// How it works
// - after power-down release, acquire the link; lock flag floats or reads low.
// - once acquisition completes, drive the lock flag high.
// - while powered down, every output group floats.
// - enabled, idle low, static link: all low, clock may run oscillator.
// - enabled, idle high, static link: pass holds, lock, data, clock low.
// - enabled, idle low, active link: lock high, other groups held low.
// - enabled, idle high, active link: lock high and all groups valid.
// - low-frequency select low means normal 15 to 85 MHz pixel range.
// - low-frequency select high means 5 to under 15 MHz pixel range.
// - frequency select comes from a register or from the strap level.
// - a low downstream interrupt is carried upstream as a low request.
// - configuration comes from the strap level or from register bits.
// - strap settings decode frequency, repeater, legacy and aux-lane controls.
// - repeater and legacy mode default off; legacy limits range to 65 MHz.
// - aux lane off gives 24-bit colour; on gives 18-bit plus audio lane.
// - one register bit enables the oscillator clock when the link is lost while enabled with idle low.
// - link counts as static when embedded clock bits are absent.
package dsm_pkg;
	localparam int CLK_NS = 100;
	localparam int STOP_NS = 2000;
	localparam int STOP_CYC = (STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_WORDS = 8;
	localparam int OSC_HALF = 2;
	localparam int DATA_W = 24;
	localparam int COLOR18_W = 18;
	localparam int STRAP_W = 8;
	localparam int NUM_THR = 8;
	localparam int CNT_W = 8;
	// strap thresholds, level scaled so that full supply reads 8'hFF
	localparam logic [STRAP_W-1:0] STRAP_THR [NUM_THR] = '{
		8'h0F, 8'h23, 8'h32, 8'h46, 8'h5B, 8'h72, 8'h89, 8'h9A};
	localparam logic [3:0] SET_LF_LO = 4'h5;
	localparam logic [3:0] SET_LF_HI = 4'h8;
	localparam logic [3:0] SET_LEGACY = 4'h9;
	// pixel clock ranges in MHz per mode
	localparam int PCLK_NORM_MIN_MHZ = 15;
	localparam int PCLK_NORM_MAX_MHZ = 85;
	localparam int PCLK_LF_MIN_MHZ = 5;
	localparam int PCLK_LF_LIMIT_MHZ = 15;
	localparam int PCLK_LEGACY_MAX_MHZ = 65;
endpackage

// ==== src/dsm_sync2.sv ====
// dsm_sync2: two-flop synchroniser for levels and handshake toggles.
// assumes each bit is a level that is stable for several destination clocks.
`timescale 1ns/100ps
module dsm_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	if (W < 1)
	begin : g_bad_w
		$error("dsm_sync2: W must be at least 1");
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_r <= '0;
			q_o <= '0;
		end
		else
		begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule

// ==== src/dsm_strap_dec.sv ====
// dsm_strap_dec: turns the digitised strap level into mode controls.
// assumes a synchronised, settled level; caller samples the result.
`timescale 1ns/100ps
module dsm_strap_dec
	import dsm_pkg::*;
(
	input wire logic [STRAP_W-1:0] level_i,
	output logic [3:0] setting_o,
	output logic low_freq_o,
	output logic repeater_o,
	output logic legacy_o,
	output logic aux_lane_o
);
	logic [NUM_THR-1:0] above;

	genvar g;
	generate
		for (g = 0; g < NUM_THR; g++)
		begin : g_thr
			assign above[g] = level_i > STRAP_THR[g];
		end
	endgenerate

	// thresholds rise monotonically, so the setting is one plus the count of passed ones
	always_comb
	begin
		setting_o = 4'h1;
		for (int i = 0; i < NUM_THR; i++)
			setting_o = setting_o + {3'h0, above[i]};
	end

	assign low_freq_o = setting_o >= SET_LF_LO && setting_o <= SET_LF_HI;
	// repeater settings 3,4,7,8 share bit 1 once counted from zero
	wire [3:0] setting_m1 = setting_o - 4'h1;
	assign repeater_o = setting_m1[1] && setting_o != SET_LEGACY;
	assign legacy_o = setting_o == SET_LEGACY;
	assign aux_lane_o = !setting_o[0] && setting_o != SET_LEGACY;
endmodule

// ==== src/dsm_top.sv ====
// dsm_top: output-state control, mode selection and interrupt forwarding.
// assumes link_clk_i is the recovered link clock, may stop, and is unrelated
// to mclk_i; link word inputs are stable around link_clk_i edges.
`timescale 1ns/100ps
module dsm_top
	import dsm_pkg::*;
#(
	parameter int LOCK_N = LOCK_WORDS,
	parameter int STOP_N = STOP_CYC
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic link_clk_i,
	input wire logic [DATA_W-1:0] link_word_i,
	input wire logic link_aux_i,
	input wire logic link_pass_i,
	input wire logic link_embclk_i,
	input wire logic powerdown_n_i,
	input wire logic output_enable_pin_i,
	input wire logic output_idle_state_select_i,
	input wire logic [STRAP_W-1:0] strap_level_select_i,
	input wire logic downstream_irq_n_in_i,
	input wire logic cfg_from_reg_i,
	input wire logic cfg_low_freq_range_select_i,
	input wire logic cfg_repeater_i,
	input wire logic cfg_legacy_i,
	input wire logic cfg_aux_audio_lane_i,
	input wire logic osc_clk_en_i,
	output logic link_locked_flag_o,
	output logic link_locked_flag_oe_o,
	output logic check_pass_flag_o,
	output logic check_pass_flag_oe_o,
	output logic [DATA_W-1:0] data_o,
	output logic aux_audio_o,
	output logic data_oe_o,
	output logic pclk_o,
	output logic pclk_oe_o,
	output logic upstream_irq_n_o,
	output logic low_freq_range_select_o,
	output logic repeater_o,
	output logic legacy_o,
	output logic aux_audio_lane_o
);
	// the counters are CNT_W bits wide and must hold both limits
	if (LOCK_N < 1 || LOCK_N > 255 || STOP_N < 2 || STOP_N > 255)
	begin : g_bad_param
		$error("dsm_top: LOCK_N or STOP_N out of range");
	end

	// ---- link domain: hold one word and offer it by toggle handshake
	logic [DATA_W-1:0] hold_word_r;
	logic hold_aux_r;
	logic hold_pass_r;
	logic hold_emb_r;
	logic req_r;
	logic ack_r;
	logic ack_l;
	wire hold_free = ack_l == req_r;

	dsm_sync2 #(.W(1)) u_ack_sync (
		.clk_i(link_clk_i),
		.reset_i(reset_i),
		.d_i(ack_r),
		.q_o(ack_l)
	);

	always_ff @(posedge link_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			hold_word_r <= '0;
			hold_aux_r <= 1'b0;
			hold_pass_r <= 1'b0;
			hold_emb_r <= 1'b0;
			req_r <= 1'b0;
		end
		else if (hold_free)
		begin
			hold_word_r <= link_word_i;
			hold_aux_r <= link_aux_i;
			hold_pass_r <= link_pass_i;
			hold_emb_r <= link_embclk_i;
			req_r <= !req_r;
		end
	end

	// ---- system domain: pins pass two flops first
	logic [STRAP_W+3:0] pins_s;
	logic req_s;
	logic req_seen_r;

	dsm_sync2 #(.W(STRAP_W + 4)) u_pin_sync (
		.clk_i(mclk_i),
		.reset_i(reset_i),
		.d_i({strap_level_select_i, powerdown_n_i, output_enable_pin_i,
			output_idle_state_select_i, !downstream_irq_n_in_i}),
		.q_o(pins_s)
	);

	dsm_sync2 #(.W(1)) u_req_sync (
		.clk_i(mclk_i),
		.reset_i(reset_i),
		.d_i(req_r),
		.q_o(req_s)
	);

	wire [STRAP_W-1:0] strap_s = pins_s[STRAP_W+3:4];
	wire pd_s = pins_s[3];
	wire oen_s = pins_s[2];
	wire oss_s = pins_s[1];
	wire irq_n_s = !pins_s[0]; // carried inverted so reset reads idle

	logic pd_d_r;
	wire pd_rise = pd_s && !pd_d_r;

	// hold regs are stable while req and ack differ, so sampling is safe
	wire new_word = req_s != req_seen_r;
	wire good_word = new_word && hold_emb_r;

	// ---- activity and lock tracking
	logic [CNT_W-1:0] idle_cnt_r;
	logic [CNT_W-1:0] lock_cnt_r;
	logic locked_r;
	wire active = idle_cnt_r < CNT_W'(STOP_N);
	wire lock_done = good_word && lock_cnt_r == CNT_W'(LOCK_N - 1);

	// a stopped link clock never ends a frame itself; the idle count does.
	// power-down parks it at the static level, as reset does
	wire [CNT_W-1:0] idle_cnt_nxt = !pd_s ? CNT_W'(STOP_N) :
		good_word ? '0 : active ? idle_cnt_r + 8'h01 : idle_cnt_r;
	wire [CNT_W-1:0] lock_cnt_nxt = !pd_s || !active ? '0 :
		good_word && !locked_r ? lock_cnt_r + 8'h01 : lock_cnt_r;
	wire locked_nxt = pd_s && active && (locked_r || lock_done);
	wire link_up = locked_r && active;

	// ---- mode selection, sampled at power-down release
	logic [3:0] strap_setting;
	logic st_lf;
	logic st_rep;
	logic st_leg;
	logic st_aux;

	dsm_strap_dec u_strap (
		.level_i(strap_s),
		.setting_o(strap_setting),
		.low_freq_o(st_lf),
		.repeater_o(st_rep),
		.legacy_o(st_leg),
		.aux_lane_o(st_aux)
	);

	wire lf_sel = cfg_from_reg_i ? cfg_low_freq_range_select_i : st_lf;
	wire rep_sel = cfg_from_reg_i ? cfg_repeater_i : st_rep;
	wire leg_sel = cfg_from_reg_i ? cfg_legacy_i : st_leg;
	wire aux_sel = cfg_from_reg_i ? cfg_aux_audio_lane_i : st_aux;

	// ---- captured pixel word
	logic [DATA_W-1:0] word_r;
	logic aux_r;
	logic pass_r;
	wire [DATA_W-1:0] word_shown = aux_audio_lane_o ?
		{{(DATA_W - COLOR18_W){1'b0}}, word_r[COLOR18_W-1:0]} : word_r;
	wire aux_shown = aux_audio_lane_o && aux_r;

	// ---- oscillator and pixel clock generation
	logic [CNT_W-1:0] osc_cnt_r;
	wire osc_tick = osc_cnt_r == CNT_W'(OSC_HALF - 1);
	wire [CNT_W-1:0] osc_cnt_nxt = osc_tick ? '0 : osc_cnt_r + 8'h01;

	// ---- output state decode
	wire run_valid = link_up && oen_s && oss_s;
	wire static_osc = !active && oen_s && !oss_s && osc_clk_en_i;
	wire lock_oe_nxt = pd_s && (locked_r || oen_s || !oss_s);
	wire lock_nxt = link_up && lock_oe_nxt;
	wire grp_oe_nxt = pd_s && (oen_s || !oss_s);
	wire pass_nxt = run_valid ? pass_r :
		(pd_s && oen_s && oss_s && !active) ? check_pass_flag_o : 1'b0;
	wire [DATA_W-1:0] data_nxt = run_valid ? word_shown : '0;
	wire aux_nxt = run_valid && aux_shown;
	wire pclk_nxt = run_valid ? !pclk_o :
		static_osc ? pclk_o ^ osc_tick : 1'b0;
	wire irq_n_nxt = irq_n_s;

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			req_seen_r <= 1'b0;
			ack_r <= 1'b0;
			word_r <= '0;
			aux_r <= 1'b0;
			pass_r <= 1'b0;
		end
		else if (new_word)
		begin
			req_seen_r <= req_s;
			ack_r <= req_s;
			word_r <= hold_word_r;
			aux_r <= hold_aux_r;
			pass_r <= hold_pass_r;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pd_d_r <= 1'b0;
			idle_cnt_r <= CNT_W'(STOP_N);
			lock_cnt_r <= '0;
			locked_r <= 1'b0;
			osc_cnt_r <= '0;
		end
		else
		begin
			pd_d_r <= pd_s;
			idle_cnt_r <= idle_cnt_nxt;
			lock_cnt_r <= lock_cnt_nxt;
			locked_r <= locked_nxt;
			osc_cnt_r <= osc_cnt_nxt;
		end
	end

	// modes default off; only a release re-reads strap or registers
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			low_freq_range_select_o <= 1'b0;
			repeater_o <= 1'b0;
			legacy_o <= 1'b0;
			aux_audio_lane_o <= 1'b0;
		end
		else if (pd_rise)
		begin
			low_freq_range_select_o <= lf_sel;
			repeater_o <= rep_sel;
			legacy_o <= leg_sel;
			aux_audio_lane_o <= aux_sel;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			link_locked_flag_o <= 1'b0;
			link_locked_flag_oe_o <= 1'b0;
			check_pass_flag_o <= 1'b0;
			check_pass_flag_oe_o <= 1'b0;
			data_o <= '0;
			aux_audio_o <= 1'b0;
			data_oe_o <= 1'b0;
			pclk_o <= 1'b0;
			pclk_oe_o <= 1'b0;
			upstream_irq_n_o <= 1'b1;
		end
		else
		begin
			link_locked_flag_o <= lock_nxt;
			link_locked_flag_oe_o <= lock_oe_nxt;
			check_pass_flag_o <= pass_nxt;
			check_pass_flag_oe_o <= grp_oe_nxt;
			data_o <= data_nxt;
			aux_audio_o <= aux_nxt;
			data_oe_o <= grp_oe_nxt;
			pclk_o <= pclk_nxt;
			pclk_oe_o <= grp_oe_nxt;
			upstream_irq_n_o <= irq_n_nxt;
		end
	end

	// ---- checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	sequence lock_step_s;
		pd_s && active && !locked_r && good_word;
	endsequence

	sequence static_hi_s;
		pd_s && oen_s && oss_s && !active;
	endsequence

	pd_tristate_a: assert property (
		!pd_s |=> !link_locked_flag_oe_o && !check_pass_flag_oe_o &&
			!data_oe_o && !pclk_oe_o)
		else $error("outputs driven during power-down");

	lock_count_a: assert property (
		$rose(locked_r) |-> $past(lock_cnt_r) == CNT_W'(LOCK_N - 1) &&
			$past(good_word))
		else $error("lock declared without full word count");

	lock_flag_a: assert property (
		lock_step_s ##1 locked_r && pd_s |=> link_locked_flag_o)
		else $error("lock flag not raised after lock");

	oen_low_drive_a: assert property (
		pd_s && !oen_s && !oss_s |=> data_oe_o && pclk_oe_o &&
			data_o == '0 && !pclk_o && !check_pass_flag_o &&
			link_locked_flag_o == ($past(locked_r) && $past(active)))
		else $error("enable-low idle-low state wrong");

	oen_low_float_a: assert property (
		pd_s && !oen_s && oss_s |=> !data_oe_o && !pclk_oe_o &&
			!check_pass_flag_oe_o)
		else $error("enable-low idle-high groups not floating");

	static_osc_a: assert property (
		pd_s && oen_s && !oss_s && !active |=> !link_locked_flag_o &&
			data_o == '0 && (pclk_o == 1'b0 || $past(osc_clk_en_i)))
		else $error("static idle-low outputs not low");

	pass_hold_a: assert property (
		static_hi_s ##1 static_hi_s |=> $stable(check_pass_flag_o) &&
			data_o == '0 && !pclk_o)
		else $error("pass flag not held on static link");

	active_idle_a: assert property (
		pd_s && active && oen_s && !oss_s && locked_r |=> link_locked_flag_o &&
			data_o == '0 && !check_pass_flag_o && !pclk_o)
		else $error("active idle-low outputs not low");

	valid_data_a: assert property (
		run_valid && pd_s |=> data_o == $past(word_shown) &&
			check_pass_flag_o == $past(pass_r))
		else $error("valid data not presented");

	stop_detect_a: assert property (
		pd_s && !good_word && idle_cnt_r == CNT_W'(STOP_N - 1) |=>
			!active ##1 !locked_r)
		else $error("static link not detected");

	mode_hold_a: assert property (
		!pd_rise |=> $stable(low_freq_range_select_o) &&
			$stable(repeater_o) && $stable(legacy_o) &&
			$stable(aux_audio_lane_o))
		else $error("mode changed without power-down release");

	irq_fwd_a: assert property (
		$fell(irq_n_s) |=> !upstream_irq_n_o)
		else $error("downstream interrupt not forwarded");

	lock_float_a: assert property (
		pd_s && !locked_r && !oen_s && oss_s |=> !link_locked_flag_oe_o)
		else $error("lock flag driven while acquiring with outputs off");

	narrow_color_a: assert property (
		aux_audio_lane_o |=> data_o[DATA_W-1:COLOR18_W] == '0)
		else $error("upper colour bits driven in 18-bit mode");
endmodule

// ==== verif/dsm_link_model.sv ====
// dsm_link_model: upstream serializer as seen at the recovered link side.
// assumes run_i starts and stops the stream; clock stands still when stopped.
`timescale 1ns/100ps
module dsm_link_model
	import dsm_pkg::*;
(
	input wire logic run_i,
	input wire logic [DATA_W-1:0] word_i,
	input wire logic aux_i,
	input wire logic pass_i,
	input wire logic irq_en_i,
	input wire logic irq_n_i,
	input wire logic status_rd_i,
	output logic link_clk_o,
	output logic [DATA_W-1:0] word_o,
	output logic aux_o,
	output logic pass_o,
	output logic embclk_o,
	output logic host_irq_n_o
);
	logic pend_r = 1'b0;
	initial
	begin
		link_clk_o = 1'b0;
		word_o = 24'h000000;
		aux_o = 1'b0;
		pass_o = 1'b0;
		embclk_o = 1'b0;
		#13;
		forever
		begin
			#40;
			link_clk_o = run_i ? ~link_clk_o : 1'b0;
			// stopped stream: no embedded clock, lines churn
			if (!link_clk_o)
			begin
				embclk_o = run_i;
				word_o = run_i ? word_i : ~word_o;
				aux_o = run_i ? aux_i : ~aux_o;
				pass_o = run_i ? pass_i : ~pass_o;
			end
		end
	end

	// back channel: a falling request latches until the host reads status
	always @(negedge irq_n_i or posedge status_rd_i)
	begin
		if (status_rd_i)
			pend_r = 1'b0;
		else if (irq_en_i)
			pend_r = 1'b1;
	end

	assign host_irq_n_o = !pend_r;
endmodule

// ==== verif/tb_top.sv ====
// tb_top: output-state, mode select and interrupt forwarding bench.
// assumes dsm_top with assertions inside and a link model at its far side.
`timescale 1ns/100ps
module tb_top;
	import dsm_pkg::*;
	logic mclk_i;
	logic reset_i;
	logic pd_n = 1'b0, output_enable_pin = 1'b0, oss = 1'b0, irq_n = 1'b1;
	logic from_reg = 1'b0, c_lf = 1'b0, c_rep = 1'b0, c_leg = 1'b0;
	logic c_aux = 1'b0, osc_en = 1'b0, run = 1'b0, aux_b = 1'b0;
	logic pass_b = 1'b0, irq_en = 1'b0, st_rd = 1'b0;
	logic [7:0] strap = 8'h00;
	logic [23:0] word = 24'h000000;
	wire l_clk, l_aux, l_pass, l_emb;
	wire [23:0] l_word, dat;
	wire lk, lk_oe, ps, ps_oe, dv_oe, pc, pc_oe, up_n;
	wire m_lf, m_rep, m_leg, m_aux, a_out, host_n;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] lv [9] = '{8'h00, 8'h1F, 8'h27, 8'h3E, 8'h4F, 8'h66,
		8'h7D, 8'h95, 8'hA0};
	logic [3:0] md [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC,
		4'hD, 4'h2};

	dsm_link_model dsm_link_model_i (.run_i(run), .word_i(word),
		.aux_i(aux_b), .pass_i(pass_b), .link_clk_o(l_clk),
		.word_o(l_word), .aux_o(l_aux), .pass_o(l_pass), .embclk_o(l_emb),
		.irq_en_i(irq_en), .irq_n_i(up_n), .status_rd_i(st_rd),
		.host_irq_n_o(host_n));

	dsm_top #(.LOCK_N(2), .STOP_N(20)) dsm_top_i (.mclk_i(mclk_i),
		.reset_i(reset_i), .link_clk_i(l_clk), .link_word_i(l_word),
		.link_aux_i(l_aux), .link_pass_i(l_pass), .link_embclk_i(l_emb),
		.powerdown_n_i(pd_n), .output_enable_pin_i(output_enable_pin),
		.output_idle_state_select_i(oss), .strap_level_select_i(strap),
		.downstream_irq_n_in_i(irq_n), .cfg_from_reg_i(from_reg),
		.cfg_low_freq_range_select_i(c_lf), .cfg_repeater_i(c_rep),
		.cfg_legacy_i(c_leg), .cfg_aux_audio_lane_i(c_aux),
		.osc_clk_en_i(osc_en), .link_locked_flag_o(lk),
		.link_locked_flag_oe_o(lk_oe), .check_pass_flag_o(ps),
		.check_pass_flag_oe_o(ps_oe), .data_o(dat), .aux_audio_o(a_out),
		.data_oe_o(dv_oe), .pclk_o(pc), .pclk_oe_o(pc_oe),
		.upstream_irq_n_o(up_n), .low_freq_range_select_o(m_lf),
		.repeater_o(m_rep), .legacy_o(m_leg), .aux_audio_lane_o(m_aux));

	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		comparisons++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// power-down cycle with a new strap level
	task automatic pwr(input logic [7:0] l);
		cyc(1);
		pd_n = 1'b0;
		strap = l;
		cyc(5);
		pd_n = 1'b1;
		cyc(6);
	endtask

	task automatic pins(input logic e, input logic s);
		output_enable_pin = e;
		oss = s;
		cyc(5);
	endtask

	task automatic wait_lock(input logic e);
		for (int i = 0; i < 80 && lk !== e; i++)
			cyc(1);
	endtask

	// enables {lock,pass,data,pclk}; lock and pass values checked only where driven
	task automatic st(input logic [3:0] oe, input logic l, input logic p);
		chk("oe", {20'h0, oe}, {20'h0, lk_oe, ps_oe, dv_oe, pc_oe});
		chk("vals", {22'h0, {l, p} & oe[3:2]}, {22'h0, {lk, ps} & oe[3:2]});
	endtask

	task automatic tog(input logic e);
		logic a, t;
		a = pc;
		t = 1'b0;
		if (!e)
			chk("pclk", 24'h0, {23'h0, pc});
		repeat (6)
		begin
			cyc(1);
			if (pc !== a)
				t = 1'b1;
		end
		chk("pclk_run", {23'h0, e}, {23'h0, t});
	endtask

	task automatic modes(input logic [3:0] e);
		chk("modes", {20'h0, e}, {20'h0, m_lf, m_rep, m_leg, m_aux});
	endtask

	task automatic wrap_up;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		#500_000;
		failures++;
		wrap_up;
	end

	initial
	begin
		reset_i = 1'b1;
		cyc(4);
		reset_i = 1'b0;
		cyc(1);
		st(4'h0, 1'b0, 1'b0);
		modes(4'h0);
		for (int s = 0; s < 9; s++)
		begin
			pwr(lv[s]);
			modes(md[s]);
		end
		strap = 8'h00;
		from_reg = 1'b1;
		c_lf = 1'b1;
		c_rep = 1'b1;
		c_aux = 1'b1;
		cyc(5);
		modes(4'h2);
		pwr(8'h00);
		modes(4'hD);
		c_lf = 1'b0;
		c_rep = 1'b0;
		c_leg = 1'b1;
		c_aux = 1'b0;
		pwr(8'h00);
		modes(4'h2);
		$display("test modes done");
		pins(1'b1, 1'b0);
		st(4'hF, 1'b0, 1'b0);
		tog(1'b0);
		osc_en = 1'b1;
		cyc(3);
		tog(1'b1);
		osc_en = 1'b0;
		pins(1'b0, 1'b1);
		st(4'h0, 1'b0, 1'b0);
		word = 24'hA5C3E1;
		pass_b = 1'b1;
		aux_b = 1'b1;
		run = 1'b1;
		pins(1'b1, 1'b1);
		wait_lock(1'b1);
		st(4'hF, 1'b1, 1'b1);
		chk("data", 24'hA5C3E1, dat);
		chk("aux", 24'h0, {23'h0, a_out});
		tog(1'b1);
		pins(1'b1, 1'b0);
		st(4'hF, 1'b1, 1'b0);
		chk("data", 24'h0, dat);
		tog(1'b0);
		pins(1'b0, 1'b0);
		st(4'hF, 1'b1, 1'b0);
		chk("data", 24'h0, dat);
		pins(1'b0, 1'b1);
		st(4'h8, 1'b1, 1'b0);
		pins(1'b1, 1'b1);
		run = 1'b0;
		wait_lock(1'b0);
		cyc(2);
		st(4'hF, 1'b0, 1'b1);
		chk("data", 24'h0, dat);
		tog(1'b0);
		$display("test outputs done");
		c_aux = 1'b1;
		pwr(8'h00);
		run = 1'b1;
		wait_lock(1'b1);
		chk("data", 24'h01C3E1, dat);
		chk("aux", 24'h1, {23'h0, a_out});
		pd_n = 1'b0;
		cyc(5);
		st(4'h0, 1'b0, 1'b0);
		$display("test aux lane done");
		irq_en = 1'b1;
		irq_n = 1'b0;
		cyc(2);
		chk("irq", 24'h1, {23'h0, up_n});
		cyc(1);
		chk("irq", 24'h0, {23'h0, up_n});
		chk("host_irq", 24'h0, {23'h0, host_n});
		st_rd = 1'b1;
		cyc(1);
		st_rd = 1'b0;
		chk("host_irq", 24'h1, {23'h0, host_n});
		irq_n = 1'b1;
		cyc(3);
		chk("irq", 24'h1, {23'h0, up_n});
		irq_n = 1'b0;
		cyc(3);
		chk("host_irq", 24'h0, {23'h0, host_n});
		$display("test interrupt done");
		wrap_up;
	end
endmodule
